// file: rtl/psb_burst_counter.sv
// Purpose: Two-bit wraparound burst counter, interleaved or linear order
// Assumes: Load has priority over a step in the same cycle
// Notes:   Offers the current and the following low address bits
`timescale 1ns/1ps
module psb_burst_counter (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         load,
    input  wire logic [psb_pkg::BURST_W-1:0]  start,
    input  wire logic                         step,
    input  wire logic                         linear,
    output logic      [psb_pkg::BURST_W-1:0]  cur,
    output logic      [psb_pkg::BURST_W-1:0]  nxt
);
    logic [psb_pkg::BURST_W-1:0] start_q;
    logic [psb_pkg::BURST_W-1:0] count;
    logic [psb_pkg::BURST_W-1:0] count_inc;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_q <= psb_pkg::BURST_RESET;
            count   <= psb_pkg::BURST_RESET;
        end else if (load) begin
            start_q <= start;
            count   <= psb_pkg::BURST_RESET;
        end else if (step) begin
            count <= count_inc;
        end
    end

    assign count_inc = count + psb_pkg::BURST_STEP;
    // Both orders wrap naturally in two bits
    assign cur = linear ? start_q + count : start_q ^ count;
    assign nxt = linear ? start_q + count_inc : start_q ^ count_inc;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_linear_step: assert property (linear |-> nxt == cur + psb_pkg::BURST_STEP)
        else $error("linear burst order broken");
    a_interleave_step: assert property (
        step && !load && !linear |=> cur == ($past(start_q) ^ ($past(count) + 2'h1)))
        else $error("interleaved burst order broken");
    a_load_start: assert property (load |=> cur == $past(start))
        else $error("burst counter not loaded from low address bits");
endmodule : psb_burst_counter

// file: rtl/psb_pkg.sv
// Purpose: Shared constants and types of the pipelined burst SRAM access logic
// Assumes: 64K words of 32 bits, four byte lanes, one 25 MHz clock
// Notes:   Sleep transition figures are counted in clock cycles; recovery is also given in ns
package psb_pkg;
    localparam int ADDR_W             = 16;
    localparam int DATA_W             = 32;
    localparam int LANES              = 4;
    localparam int LANE_W             = 8;
    localparam int BURST_W            = 2;
    localparam int WORDS              = 65536;
    localparam int CLK_PERIOD_NS      = 40;
    // Sleep entry and exit in clock cycles; recovery also in ns
    localparam int SLEEP_ENTER_CYCLES = 2;
    localparam int SLEEP_EXIT_CYCLES  = 2;
    localparam int SLEEP_RECOVERY_NS  = SLEEP_EXIT_CYCLES * CLK_PERIOD_NS;
    localparam logic [1:0] SLEEP_CNT_RESET = 2'h0;
    localparam logic [1:0] BURST_RESET     = 2'h0;
    localparam logic [1:0] BURST_STEP      = 2'h1;
    localparam logic [1:0] ENTER_LAST = 2'(SLEEP_ENTER_CYCLES - 2);
    localparam logic [1:0] EXIT_LAST  = 2'(SLEEP_EXIT_CYCLES - 2);

    typedef enum logic [1:0] {
        PSB_AWAKE,
        PSB_ENTER,
        PSB_SLEEP,
        PSB_EXIT
    } psb_sleep_t;
endpackage : psb_pkg

// file: rtl/psb_sram_access.sv
// Purpose: Synchronous access logic of a pipelined 64K x 32 burst SRAM
// Assumes: Synchronous pins come from logic on CLK_SYS; sleep and strap are asynchronous
// Notes:   Output enable is gated straight into the drive enable, as on the pin
//
// Function
// - Read starts on a strobe with all selects active and write inputs high.
// - Accepted read loads address and counter; data leaves the output register next edge.
// - First cycle after becoming selected keeps the data outputs undriven.
// - Back-to-back reads work; a deselecting strobe turns outputs off at the next edge.
// - Processor strobe access captures address; write inputs and advance ignored then.
// - Processor strobe write takes two cycles; global write stores all bytes.
// - With global write high, byte enable and lane selects pick written bytes.
// - Any detected write cycle turns the data drivers off regardless of enable.
// - Controller strobe write completes in one cycle, loading address and counter.
// - Burst advance is ignored during the controller strobe write.
// - Controller strobe write: global stores all bytes, byte write only selected.
// - Two-bit wraparound counter loads from low address bits, order by strap.
// - Advance low at a clock rise steps the counter, for reads and writes.
// - Strap high or open: interleaved order, start XOR count.
// - Strap low: linear order, incrementing modulo four.
// - Sleep input enters a content-keeping low-power state; two cycles each way.
// - Accesses pending at sleep entry are dropped.
// - Output enable high keeps data pins undriven; low during a read drives them.
// - Strap low selects linear, high or open interleaved; expected static.
// - A processor strobe cycle is always a read; writes come later or by controller strobe.
`timescale 1ns/1ps
module psb_sram_access (
    input  wire logic                        CLK_SYS,
    input  wire logic                        RESET,
    input  wire logic [psb_pkg::ADDR_W-1:0]  ADDR,
    input  wire logic [psb_pkg::DATA_W-1:0]  DQ_IN,
    output logic      [psb_pkg::DATA_W-1:0]  DQ_OUT,
    output logic                             DQ_OE_N,
    input  wire logic                        PRIMARY_CHIP_SELECT_N,
    input  wire logic                        DEPTH_CHIP_SELECT,
    input  wire logic                        DEPTH_CHIP_SELECT_N,
    input  wire logic                        PROCESSOR_ADDRESS_STROBE_N,
    input  wire logic                        CONTROLLER_ADDRESS_STROBE_N,
    input  wire logic                        BURST_ADVANCE_N,
    input  wire logic                        GLOBAL_WRITE_N,
    input  wire logic                        BYTE_WRITE_ENABLE_N,
    input  wire logic [psb_pkg::LANES-1:0]   BYTE_LANE_SELECT_N,
    input  wire logic                        OUTPUT_ENABLE_N,
    input  wire logic                        SLEEP_REQUEST,
    input  wire logic                        BURST_ORDER_SELECT,
    output logic                             SLEEP_ACTIVE
);
    logic                         zz_meta;
    logic                         zz_s;
    logic                         strap_meta;
    logic                         strap_s;
    logic                         linear;
    psb_pkg::psb_sleep_t          sleep_state;
    logic [1:0]                   sleep_cnt;
    logic                         awake;
    logic                         selected;
    logic                         processor_address_strobe_n_hit;
    logic                         controller_address_strobe_n_hit;
    logic                         strobe;
    logic                         deselect;
    logic                         processor_address_strobe_n_acc;
    logic                         controller_address_strobe_n_acc;
    logic [psb_pkg::LANES-1:0]    lane_we;
    logic                         wr_any;
    logic                         cont;
    logic                         step;
    logic                         do_write;
    logic                         do_read;
    logic                         active;
    logic [psb_pkg::ADDR_W-1:2]   addr_hi;
    logic [1:0]                   burst_cur;
    logic [1:0]                   burst_nxt;
    logic [psb_pkg::ADDR_W-1:0]   burst_addr;
    logic [psb_pkg::ADDR_W-1:0]   acc_addr;
    logic                         rd_pend;
    logic [psb_pkg::ADDR_W-1:0]   rd_addr;
    logic                         dout_valid;

    // Asynchronous pins pass two flip-flops before use
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            zz_meta    <= 1'b0;
            zz_s       <= 1'b0;
            strap_meta <= 1'b1;
            strap_s    <= 1'b1;
        end else begin
            zz_meta    <= SLEEP_REQUEST;
            zz_s       <= zz_meta;
            strap_meta <= BURST_ORDER_SELECT;
            strap_s    <= strap_meta;
        end
    end

    // Strap is static; a change mid-burst also remaps the current burst address
    assign linear = !strap_s;

    // Sleep state: entry and exit each span two edges of the synced request
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            sleep_state <= psb_pkg::PSB_AWAKE;
            sleep_cnt   <= psb_pkg::SLEEP_CNT_RESET;
        end else begin
            unique case (sleep_state)
                psb_pkg::PSB_AWAKE: begin
                    sleep_cnt <= psb_pkg::SLEEP_CNT_RESET;
                    if (zz_s) begin
                        sleep_state <= psb_pkg::PSB_ENTER;
                    end
                end
                psb_pkg::PSB_ENTER: begin
                    if (sleep_cnt == psb_pkg::ENTER_LAST) begin
                        sleep_state <= psb_pkg::PSB_SLEEP;
                        sleep_cnt   <= psb_pkg::SLEEP_CNT_RESET;
                    end else begin
                        sleep_cnt <= sleep_cnt + 2'h1;
                    end
                end
                psb_pkg::PSB_SLEEP: begin
                    if (!zz_s) begin
                        sleep_state <= psb_pkg::PSB_EXIT;
                    end
                end
                psb_pkg::PSB_EXIT: begin
                    if (zz_s) begin
                        sleep_state <= psb_pkg::PSB_SLEEP;
                        sleep_cnt   <= psb_pkg::SLEEP_CNT_RESET;
                    end else if (sleep_cnt == psb_pkg::EXIT_LAST) begin
                        sleep_state <= psb_pkg::PSB_AWAKE;
                        sleep_cnt   <= psb_pkg::SLEEP_CNT_RESET;
                    end else begin
                        sleep_cnt <= sleep_cnt + 2'h1;
                    end
                end
            endcase
        end
    end

    assign awake        = (sleep_state == psb_pkg::PSB_AWAKE);
    assign SLEEP_ACTIVE = (sleep_state == psb_pkg::PSB_SLEEP);

    // Access decode
    assign selected = !PRIMARY_CHIP_SELECT_N && DEPTH_CHIP_SELECT && !DEPTH_CHIP_SELECT_N;
    // Processor strobe is ignored while the primary select is high
    assign processor_address_strobe_n_hit = awake && !PROCESSOR_ADDRESS_STROBE_N && !PRIMARY_CHIP_SELECT_N;
    // Processor strobe wins when both strobes are low
    assign controller_address_strobe_n_hit = awake && !CONTROLLER_ADDRESS_STROBE_N && !processor_address_strobe_n_hit;
    assign strobe   = processor_address_strobe_n_hit || controller_address_strobe_n_hit;
    assign deselect = strobe && !selected;
    assign processor_address_strobe_n_acc = processor_address_strobe_n_hit && selected;
    assign controller_address_strobe_n_acc = controller_address_strobe_n_hit && selected;

    genvar gi;
    generate
        for (gi = 0; gi < psb_pkg::LANES; gi++) begin : g_lane
            logic [psb_pkg::LANE_W-1:0] mem [0:psb_pkg::WORDS-1];
            logic [psb_pkg::LANE_W-1:0] lane_q;

            // Global write overrides the byte controls
            assign lane_we[gi] = !GLOBAL_WRITE_N
                || (!BYTE_WRITE_ENABLE_N && !BYTE_LANE_SELECT_N[gi]);

            // Unselected lanes are simply not written
            always_ff @(posedge CLK_SYS) begin
                if (do_write && lane_we[gi]) begin
                    mem[acc_addr] <= DQ_IN[gi*psb_pkg::LANE_W +: psb_pkg::LANE_W];
                end
            end

            // Output register; no reset so the array maps onto plain RAM
            always_ff @(posedge CLK_SYS) begin
                if (rd_pend) begin
                    lane_q <= mem[rd_addr];
                end
            end

            assign DQ_OUT[gi*psb_pkg::LANE_W +: psb_pkg::LANE_W] = lane_q;
        end
    endgenerate

    assign wr_any = |lane_we;
    assign cont   = awake && active && !strobe;
    assign step   = cont && !BURST_ADVANCE_N;

    // Processor strobe cycle never writes, whatever the write inputs show
    assign do_write = (controller_address_strobe_n_acc && wr_any) || (cont && wr_any);
    assign do_read  = processor_address_strobe_n_acc || (controller_address_strobe_n_acc && !wr_any) || (cont && !wr_any);

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            active  <= 1'b0;
            addr_hi <= '0;
        end else if (!awake || deselect) begin
            active <= 1'b0;
        end else if (processor_address_strobe_n_acc || controller_address_strobe_n_acc) begin
            active  <= 1'b1;
            addr_hi <= ADDR[psb_pkg::ADDR_W-1:2];
        end
    end

    // Strobe cycles load the counter, so advance is ignored there
    psb_burst_counter u_burst (
        .clk    (CLK_SYS),
        .rst    (RESET),
        .load   (processor_address_strobe_n_acc || controller_address_strobe_n_acc),
        .start  (ADDR[1:0]),
        .step   (step),
        .linear (linear),
        .cur    (burst_cur),
        .nxt    (burst_nxt)
    );

    assign burst_addr = {addr_hi, step ? burst_nxt : burst_cur};
    assign acc_addr   = strobe ? ADDR : burst_addr;

    // Read pipeline: address at one edge, output register at the next
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            rd_pend <= 1'b0;
            rd_addr <= '0;
        end else begin
            rd_pend <= do_read;
            if (do_read) begin
                rd_addr <= acc_addr;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            dout_valid <= 1'b0;
        end else if (!awake || deselect || do_write) begin
            dout_valid <= 1'b0;
        end else begin
            dout_valid <= rd_pend;
        end
    end

    // Drive only with valid read data, enable low and no write detected
    assign DQ_OE_N = !(dout_valid && !OUTPUT_ENABLE_N && !wr_any && awake);

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    sequence s_read_issue;
        do_read ##1 (awake && !deselect && !do_write);
    endsequence

    sequence s_zz_enter;
        awake && zz_s ##1 zz_s;
    endsequence

    sequence s_zz_leave;
        SLEEP_ACTIVE && !zz_s ##1 !zz_s;
    endsequence

    a_read_pipeline: assert property (s_read_issue |=> dout_valid)
        else $error("read data not registered one edge after the address");
    a_first_cycle_off: assert property (active && !$past(active) |-> DQ_OE_N)
        else $error("outputs driven in first cycle after selection");
    a_deselect_off: assert property (deselect |=> DQ_OE_N && !active)
        else $error("outputs still driven after deselect");
    a_processor_address_strobe_n_reads: assert property (processor_address_strobe_n_acc |-> do_read && !do_write)
        else $error("processor strobe cycle treated as write");
    a_write_masks_out: assert property (do_write |-> DQ_OE_N ##1 DQ_OE_N)
        else $error("data drivers on during write cycle");
    a_controller_address_strobe_n_write_addr: assert property (controller_address_strobe_n_acc && wr_any |-> do_write && acc_addr == ADDR)
        else $error("controller strobe write not at presented address");
    a_oe_high_off: assert property (OUTPUT_ENABLE_N |-> DQ_OE_N)
        else $error("data pins driven with output enable high");
    a_upper_hold: assert property (cont |=> addr_hi == $past(addr_hi))
        else $error("upper burst address changed");
    a_sleep_enter: assert property (s_zz_enter |=> SLEEP_ACTIVE)
        else $error("sleep not entered after two cycles");
    a_sleep_exit: assert property (s_zz_leave |=> awake)
        else $error("sleep not left after two cycles");
    a_sleep_drops: assert property (!awake |-> !do_read && !do_write ##1 !dout_valid)
        else $error("access performed while sleeping");
    a_sleep_hold: assert property (SLEEP_ACTIVE && zz_s |=> SLEEP_ACTIVE)
        else $error("sleep left while request still high");
    a_controller_address_strobe_n_read: assert property (controller_address_strobe_n_acc && !wr_any |-> do_read && !do_write)
        else $error("controller strobe read not started");
    a_global_lanes: assert property (!GLOBAL_WRITE_N |-> &lane_we)
        else $error("global write did not enable every lane");
    a_byte_lanes: assert property (
        GLOBAL_WRITE_N && !BYTE_WRITE_ENABLE_N |-> lane_we == ~BYTE_LANE_SELECT_N)
        else $error("byte lanes do not follow lane selects");
    a_adv_ignored: assert property ((processor_address_strobe_n_acc || controller_address_strobe_n_acc) |-> !step)
        else $error("advance acted on a strobe cycle");
    a_step_burst: assert property (step |=> burst_cur == $past(burst_nxt))
        else $error("burst counter did not step on advance");
    a_oe_low_drives: assert property (
        dout_valid && !OUTPUT_ENABLE_N && !wr_any && awake |-> !DQ_OE_N)
        else $error("read data not driven with output enable low");
endmodule : psb_sram_access

// file: sim/psb_ctrl_model.sv
// Purpose: Controller model that drives the burst SRAM bus
// Assumes: Tasks are entered at a falling edge and return at one
// Notes:   Released data lines show the inverse of the last word
`timescale 1ns/1ps
module psb_ctrl_model (
    input  wire logic                   clk,
    output logic [psb_pkg::ADDR_W-1:0]  addr,
    output logic [psb_pkg::DATA_W-1:0]  dq_in,
    output logic                        pcs_n,
    output logic                        dcs,
    output logic                        dcs_n,
    output logic                        processor_address_strobe_n_n,
    output logic                        controller_address_strobe_n_n,
    output logic                        adv_n,
    output logic                        gw_n,
    output logic                        bwe_n,
    output logic [psb_pkg::LANES-1:0]   bls_n,
    output logic                        oe_n,
    output logic                        zz
);
    initial begin
        addr = 16'h0000;
        dq_in = 32'h00000000;
        {pcs_n, dcs, dcs_n} = 3'h2;
        {processor_address_strobe_n_n, controller_address_strobe_n_n, adv_n, gw_n, bwe_n, bls_n} = 9'h1ff;
        {oe_n, zz} = 2'h0;
    end
    // Stale data would hide a missed sample, so the lines toggle
    task automatic idle();
        {processor_address_strobe_n_n, controller_address_strobe_n_n, gw_n, bwe_n, bls_n} = 8'hff;
        dq_in = ~dq_in;
    endtask : idle
    task automatic rd(input logic [15:0] a, input logic p);
        {pcs_n, dcs, dcs_n} = 3'h2;
        {processor_address_strobe_n_n, controller_address_strobe_n_n} = p ? 2'h1 : 2'h2;
        addr = a;
        @(negedge clk);
        idle();
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic g,
                      input logic [3:0] l);
        oe_n = 1'h1;
        @(negedge clk);
        {pcs_n, dcs, dcs_n} = 3'h2;
        {controller_address_strobe_n_n, gw_n, bwe_n, bls_n} = {1'h0, g, 1'h0, l};
        addr = a;
        dq_in = d;
        @(negedge clk);
        idle();
        oe_n = 1'h0;
    endtask : wr
    task automatic pwr(input logic [15:0] a, input logic [31:0] j, input logic [31:0] d,
                       input logic g, input logic [3:0] l);
        oe_n = 1'h1;
        @(negedge clk);
        {pcs_n, dcs, dcs_n} = 3'h2;
        {processor_address_strobe_n_n, gw_n, adv_n} = 3'h0;
        addr = a;
        dq_in = j;
        @(negedge clk);
        {processor_address_strobe_n_n, gw_n, adv_n, bwe_n, bls_n} = {1'h1, g, 2'h2, l};
        dq_in = d;
        @(negedge clk);
        idle();
        oe_n = 1'h0;
    endtask : pwr
    task automatic desel();
        {pcs_n, controller_address_strobe_n_n} = 2'h2;
        @(negedge clk);
        idle();
    endtask : desel
    task automatic nap(input logic on);
        if (on) begin
            desel();
            zz = 1'h1;
        end else begin
            zz = 1'h0;
            pcs_n = 1'h1;
            // Extra cycles cover the input synchroniser
            repeat (psb_pkg::SLEEP_EXIT_CYCLES + 3) @(negedge clk);
        end
    endtask : nap
endmodule : psb_ctrl_model

// file: sim/psb_sram_access_tb.sv
// Purpose: Self-checking bench of the burst SRAM access logic
// Assumes: A mirror memory holds every word the bench wrote
// Notes:   Words are always fully written before any read
`timescale 1ns/1ps
module psb_sram_access_tb;
    logic        clk, rst, mode, dq_oe_n, pcs_n, dcs, dcs_n, processor_address_strobe_n_n, controller_address_strobe_n_n, adv_n;
    logic        gw_n, bwe_n, oe_n, zz, asleep;
    logic [15:0] addr;
    logic [31:0] dq_in, dq_out;
    logic [3:0]  bls_n;
    logic [31:0] mem [logic [15:0]];
    int          err_count = 0;
    int          comparisons = 0;
    psb_sram_access dut_u (.CLK_SYS(clk), .RESET(rst), .ADDR(addr), .DQ_IN(dq_in),
        .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .PRIMARY_CHIP_SELECT_N(pcs_n),
        .DEPTH_CHIP_SELECT(dcs), .DEPTH_CHIP_SELECT_N(dcs_n),
        .PROCESSOR_ADDRESS_STROBE_N(processor_address_strobe_n_n), .CONTROLLER_ADDRESS_STROBE_N(controller_address_strobe_n_n),
        .BURST_ADVANCE_N(adv_n), .GLOBAL_WRITE_N(gw_n), .BYTE_WRITE_ENABLE_N(bwe_n),
        .BYTE_LANE_SELECT_N(bls_n), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(zz),
        .BURST_ORDER_SELECT(mode), .SLEEP_ACTIVE(asleep));
    psb_ctrl_model ctl_u (.clk(clk), .addr(addr), .dq_in(dq_in), .pcs_n(pcs_n),
        .dcs(dcs), .dcs_n(dcs_n), .processor_address_strobe_n_n(processor_address_strobe_n_n), .controller_address_strobe_n_n(controller_address_strobe_n_n), .adv_n(adv_n),
        .gw_n(gw_n), .bwe_n(bwe_n), .bls_n(bls_n), .oe_n(oe_n), .zz(zz));
    task automatic close_out();
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %b got %b", n, e, g);
        end
    endtask : chk_bit
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] l);
        for (int i = 0; i < 4; i++) begin
            if (!l[i]) o[8*i +: 8] = d[8*i +: 8];
        end
        return o;
    endfunction : merge
    task automatic w(input logic [15:0] a, input logic [31:0] d, input logic g,
                     input logic [3:0] l);
        ctl_u.wr(a, d, g, l);
        mem[a] = g ? merge(mem[a], d, l) : d;
    endtask : w
    task automatic rchk(input logic [15:0] a, input logic p);
        ctl_u.rd(a, p);
        @(negedge clk);
        chk_word("dq_out", mem[a], dq_out);
        chk_bit("dq_oe_n", 1'h0, dq_oe_n);
    endtask : rchk
    task automatic wait_sleep(input logic lvl);
        int n = 0;
        while (asleep !== lvl && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk_bit("sleep_active", lvl, asleep);
        if (n >= 8) close_out();
    endtask : wait_sleep
    task automatic t_single();
        w(16'h1234, 32'h0badf00d, 1'h0, 4'h0);
        w(16'h1235, 32'h600dcafe, 1'h0, 4'h0);
        ctl_u.desel();
        ctl_u.rd(16'h1234, 1'h0);
        chk_bit("first_oe_n", 1'h1, dq_oe_n);
        @(negedge clk);
        chk_word("read_a", mem[16'h1234], dq_out);
        ctl_u.rd(16'h1235, 1'h1);
        chk_word("hold_a", mem[16'h1234], dq_out);
        @(negedge clk);
        chk_word("read_b", mem[16'h1235], dq_out);
        chk_bit("read_oe_n", 1'h0, dq_oe_n);
        ctl_u.oe_n = 1'h1;
        #1;
        chk_bit("oe_high", 1'h1, dq_oe_n);
        @(negedge clk);
        ctl_u.oe_n = 1'h0;
        {ctl_u.gw_n, ctl_u.dq_in} = {1'h0, 32'h0d0d0d0d};
        #1;
        chk_bit("write_oe_n", 1'h1, dq_oe_n);
        mem[16'h1235] = 32'h0d0d0d0d;
        @(negedge clk);
        ctl_u.gw_n = 1'h1;
        rchk(16'h1235, 1'h0);
        ctl_u.desel();
        chk_bit("desel_oe_n", 1'h1, dq_oe_n);
    endtask : t_single
    task automatic t_bytes();
        logic [3:0] m [4] = '{4'ha, 4'h5, 4'hf, 4'h7};
        w(16'h2002, 32'h00000000, 1'h0, 4'h0);
        for (int i = 0; i < 4; i++) begin
            w(16'h2002, 32'h11223344 << i, 1'h1, m[i]);
            rchk(16'h2002, 1'h1);
        end
    endtask : t_bytes
    task automatic t_processor_address_strobe_n();
        w(16'h3003, 32'h11111111, 1'h0, 4'h0);
        ctl_u.pwr(16'h3003, 32'hdeadbeef, 32'h22222222, 1'h1, 4'he);
        mem[16'h3003] = 32'h11111122;
        rchk(16'h3003, 1'h1);
        ctl_u.pwr(16'h3003, 32'hdeadbeef, 32'h33333333, 1'h0, 4'hf);
        mem[16'h3003] = 32'h33333333;
        rchk(16'h3003, 1'h0);
    endtask : t_processor_address_strobe_n
    task automatic t_burst();
        logic [1:0] lo;
        for (int i = 0; i < 4; i++) w(16'h4a4c | 16'(i), 32'h5a5a0000 | i, 1'h0, 4'h0);
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            repeat (3) @(negedge clk);
            for (int s = 0; s < 4; s++) begin
                ctl_u.rd(16'h4a4c | 16'(s), 1'h1);
                ctl_u.adv_n = 1'h0;
                for (int k = 0; k < 4; k++) begin
                    @(negedge clk);
                    lo = 2'(mode ? (s ^ k) : (s + k));
                    chk_word("burst", mem[16'h4a4c | 16'(lo)], dq_out);
                    if (k == 2) ctl_u.adv_n = 1'h1;
                end
            end
        end
        mode = 1'h1;
    endtask : t_burst
    task automatic t_sleep();
        w(16'h6006, 32'h7e570001, 1'h0, 4'h0);
        ctl_u.nap(1'h1);
        wait_sleep(1'h1);
        ctl_u.wr(16'h6006, 32'hffff0000, 1'h0, 4'h0);
        chk_bit("sleep_oe_n", 1'h1, dq_oe_n);
        ctl_u.nap(1'h0);
        wait_sleep(1'h0);
        rchk(16'h6006, 1'h0);
    endtask : t_sleep
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst = 1'h1;
        mode = 1'h1;
        repeat (3) @(negedge clk);
        chk_bit("reset_oe_n", 1'h1, dq_oe_n);
        rst = 1'h0;
        @(negedge clk);
        t_single();
        t_bytes();
        t_processor_address_strobe_n();
        t_burst();
        t_sleep();
        close_out();
    end
endmodule : psb_sram_access_tb
